// ===== shared/sns_pkg.sv
// Shared constants and types for the step note sequencer
package sns_pkg;
  localparam int MEM_DEPTH   = 40;
  localparam int PRELOAD_LEN = 20;
  localparam int KEY_W       = 6;
  localparam int ENTRY_W     = KEY_W + 1;
  localparam int REST_BIT    = KEY_W;
  localparam int CNT_W       = 6;
  localparam int NUM_KEYS    = 37;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_PERIOD_NS_DEF = 125_000_000;
  localparam logic [KEY_W-1:0] REF_KEY   = 6'h0c;
  localparam logic [KEY_W-1:0] XPOSE_TOP = 6'h18;
  localparam logic [CNT_W-1:0] CAP       = 6'h28;
  localparam logic [CNT_W-1:0] LAST_ADDR = 6'h27;
  localparam logic [1:0] BANK_OFF    = 2'h0;
  localparam logic [1:0] BANK_FIRST  = 2'h1;
  localparam logic [1:0] BANK_SECOND = 2'h2;
  localparam int REG_AW = 2;
  localparam int REG_DW = 16;
  localparam logic [REG_AW-1:0] REG_CTRL   = 2'h0;
  localparam logic [REG_AW-1:0] REG_STATUS = 2'h1;
  localparam logic [REG_AW-1:0] REG_XPOSE  = 2'h2;
  localparam int CTRL_HOLD_BIT = 0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PLAY = 3'b010,
    ST_REC  = 3'b100
  } sns_state_t;

  // Low half holds a rising scale, the top half a falling one read downward
  function automatic logic [ENTRY_W-1:0] sns_preload(input int a);
    int k;
    k = (a < PRELOAD_LEN) ? a : NUM_KEYS - MEM_DEPTH + a;
    return {1'b0, k[KEY_W-1:0]};
  endfunction
endpackage

// ===== verilog/sns_note_mem.sv
// Shared forty entry note and rest memory with power-on preload
`timescale 1ns/1ps
module sns_note_mem
  import sns_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 wr_en_in,
  input  wire logic [CNT_W-1:0]     wr_addr_in,
  input  wire logic [ENTRY_W-1:0]   wr_data_in,
  input  wire logic [CNT_W-1:0]     rd_addr_in,
  output logic      [ENTRY_W-1:0]   rd_data_out
);
  import sns_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][ENTRY_W-1:0] mem;
  } sns_mem_st_t;

  sns_mem_st_t st_r;
  sns_mem_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_en_in) begin
      st_nxt.mem[wr_addr_in] = wr_data_in;
    end
  end

  // Contents live only until the next reset, the power-on image returns
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        st_r.mem[i] <= sns_preload(i); // RULE3 RULE17
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_out = st_r.mem[rd_addr_in];
endmodule

// ===== verilog/sns_step_clock.sv
// Step tick source: internal divider or external clock pulses
`timescale 1ns/1ps
module sns_step_clock #(
  parameter int PERIOD_CYC = 8
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic restart_in,
  input  wire logic repeat_external_mode_in,
  input  wire logic ext_clk_in,
  output logic      tick_out
);
  localparam int CW = $clog2(PERIOD_CYC + 1);
  localparam logic [CW-1:0] WRAP = CW'(PERIOD_CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          ext_q;
    logic          tick;
  } sns_clk_st_t;

  sns_clk_st_t st_r;
  sns_clk_st_t st_nxt;
  logic        int_wrap;
  logic        ext_rise;

  always_comb begin
    st_nxt = st_r;
    int_wrap = (st_r.cnt == WRAP);
    ext_rise = ext_clk_in & ~st_r.ext_q;
    st_nxt.ext_q = ext_clk_in;
    st_nxt.cnt = (int_wrap || restart_in) ? '0 : st_r.cnt + 1'b1;
    // External pulses count only in repeat/external mode
    st_nxt.tick = ~restart_in & (repeat_external_mode_in ? ext_rise : int_wrap); // RULE11 RULE20
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;

  property p_ext_ignored;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (!repeat_external_mode_in && st_r.cnt != WRAP) |=> !tick_out;
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("tick without source"); // RULE20
endmodule

// ===== verilog/sns_seq_top.sv
// Two-bank step sequencer: recording, looped playback, transposition
// Functional notes
// RULE1 - One forty entry memory shared by both banks in any split.
// RULE2 - Every note or rest plays back as one equal step.
// RULE3 - Power-on preload: rising twenty-step scale first, falling second.
// RULE4 - In play, selecting a bank starts playback of that bank.
// RULE5 - Record switch then bank select; each new key note is appended.
// RULE6 - Record to play to record while recording appends one rest.
// RULE7 - Player releases keys between notes; only fresh presses record.
// RULE8 - A rest is refused as first entry of an empty bank.
// RULE9 - Entry beyond forty in one bank clears it, leaving only the new one.
// RULE10 - Player turns bank selector off before returning switch to play.
// RULE11 - Playback steps once per internal tick or external pulse.
// RULE12 - Playback wraps last to first until the bank is switched off.
// RULE13 - At forty total, recording takes memory from the other bank.
// RULE14 - The other bank is then erased; recorded bank keeps its entries.
// RULE15 - Keys are thirty-seven chromatic numbers, lowest C upward.
// RULE16 - Low two-octave key in playback transposes by offset from middle C.
// RULE17 - Contents and transposition are lost on reset.
// RULE18 - No recording while the arpeggiator is active.
// RULE19 - Arpeggiator latching via record switch leaves banks unchanged.
// RULE20 - External clock honoured only in repeat/external mode.
// RULE21 - Note step outputs transposed key with gate; rest drops gate.
// RULE22 - Playback starts at first entry; bank off stops and drops gate.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module sns_seq_top
  import sns_pkg::*;
#(
  parameter int STEP_PERIOD_NS = STEP_PERIOD_NS_DEF,
  parameter int STEP_CYC       = STEP_PERIOD_NS / CLK_PERIOD_NS
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 key_down_in,
  input  wire logic [KEY_W-1:0]     key_num_in,
  input  wire logic                 record_sel_in,
  input  wire logic [1:0]           bank_sel_in,
  input  wire logic                 arp_active_in,
  input  wire logic                 repeat_external_mode_in,
  input  wire logic                 ext_clk_in,
  input  wire logic [REG_AW-1:0]    reg_addr_in,
  input  wire logic [REG_DW-1:0]    reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [REG_DW-1:0]    reg_rdata_out,
  output logic      [ENTRY_W-1:0]   note_out,
  output logic                      gate_out,
  output logic                      playing_out,
  output logic                      recording_out
);
  import sns_pkg::*;

  typedef struct packed {
    sns_state_t          state;
    logic [1:0]          bank;
    logic [CNT_W-1:0]    idx;
    logic [CNT_W-1:0]    cnt1;
    logic [CNT_W-1:0]    cnt2;
    logic                key_q;
    logic                rec_q;
    logic                rest_arm;
    logic [KEY_W-1:0]    xpose;
    logic                hold;
    logic [ENTRY_W-1:0]  note;
    logic                gate;
    logic [REG_DW-1:0]   rdata;
  } sns_top_st_t;

  sns_top_st_t         st_r;
  sns_top_st_t         st_nxt;
  logic                tick;
  logic                fresh;
  logic                note_ev;
  logic                rest_ev;
  logic                app_en;
  logic [ENTRY_W-1:0]  app_data;
  logic [CNT_W-1:0]    wr_addr;
  logic [CNT_W-1:0]    rd_addr;
  logic [ENTRY_W-1:0]  rd_data;
  logic [CNT_W-1:0]    cur;
  logic [CNT_W-1:0]    oth;
  logic [CNT_W-1:0]    play_cnt;
  logic                first;

  sns_step_clock #(
    .PERIOD_CYC (STEP_CYC)
  ) u_clk (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .restart_in    (st_r.state != ST_PLAY),
    .repeat_external_mode_in (repeat_external_mode_in),
    .ext_clk_in    (ext_clk_in),
    .tick_out      (tick)
  );

  sns_note_mem u_mem (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .wr_en_in    (app_en),
    .wr_addr_in  (wr_addr),
    .wr_data_in  (app_data),
    .rd_addr_in  (rd_addr),
    .rd_data_out (rd_data)
  );

  // First bank fills upward from zero, second downward from the top
  assign first    = (st_r.bank == BANK_FIRST);
  assign rd_addr  = first ? st_r.idx : LAST_ADDR - st_r.idx; // RULE1
  assign play_cnt = first ? st_r.cnt1 : st_r.cnt2;
  assign fresh    = key_down_in & ~st_r.key_q; // RULE7 RULE15

  always_comb begin
    st_nxt = st_r;
    st_nxt.key_q = key_down_in;
    st_nxt.rec_q = record_sel_in;
    cur = first ? st_r.cnt1 : st_r.cnt2;
    oth = first ? st_r.cnt2 : st_r.cnt1;
    note_ev = (st_r.state == ST_REC) && fresh; // RULE5
    rest_ev = (st_r.state == ST_REC) && record_sel_in && !st_r.rec_q && st_r.rest_arm; // RULE6
    // Empty bank refuses a rest; arpeggiator blocks every write
    app_en = (note_ev || (rest_ev && cur != '0)) && !arp_active_in; // RULE8 RULE18 RULE19
    app_data = note_ev ? {1'b0, key_num_in} : {1'b1, {KEY_W{1'b0}}};
    wr_addr = first ? cur : LAST_ADDR - cur;
    if (app_en) begin
      if (cur == CAP) begin
        wr_addr = first ? '0 : LAST_ADDR; // RULE9
        cur = 6'h01;
      end else begin
        if (cur + oth >= CAP) begin
          oth = '0; // RULE13 RULE14
        end
        cur = cur + 1'b1;
      end
      st_nxt.cnt1 = first ? cur : oth;
      st_nxt.cnt2 = first ? oth : cur;
    end
    unique case (st_r.state)
      ST_IDLE: begin
        st_nxt.gate = 1'b0;
        if (bank_sel_in != BANK_OFF) begin
          st_nxt.bank = bank_sel_in;
          st_nxt.idx = '0; // RULE22
          st_nxt.rest_arm = 1'b0;
          if (!record_sel_in) begin
            st_nxt.state = ST_PLAY; // RULE4
          end else if (!arp_active_in) begin
            st_nxt.state = ST_REC; // RULE5 RULE18
          end
        end
      end
      ST_PLAY: begin
        if (bank_sel_in != st_r.bank) begin
          st_nxt.state = ST_IDLE;
          st_nxt.gate = 1'b0; // RULE22
        end else begin
          if (fresh && key_num_in <= XPOSE_TOP) begin
            st_nxt.xpose = key_num_in - REF_KEY; // RULE16
          end
          // Holding stops stepping but keeps the current step sounding
          if (tick && !st_r.hold) begin // RULE11 RULE2
            if (play_cnt == '0) begin
              st_nxt.gate = 1'b0;
            end else begin
              st_nxt.gate = ~rd_data[REST_BIT]; // RULE21
              st_nxt.note = rd_data[REST_BIT] ? st_r.note
                          : ENTRY_W'({1'b0, rd_data[KEY_W-1:0]} + {st_r.xpose[KEY_W-1], st_r.xpose});
              st_nxt.idx = (st_r.idx + 1'b1 >= play_cnt) ? '0 : st_r.idx + 1'b1; // RULE12
            end
          end
        end
      end
      ST_REC: begin
        st_nxt.gate = 1'b0;
        if (bank_sel_in != st_r.bank) begin
          st_nxt.state = ST_IDLE; // RULE10
        end else if (!record_sel_in) begin
          st_nxt.rest_arm = 1'b1;
        end else if (rest_ev) begin
          st_nxt.rest_arm = 1'b0;
        end
      end
    endcase
    if (reg_wr_in && reg_addr_in == REG_CTRL) begin
      st_nxt.hold = reg_wdata_in[CTRL_HOLD_BIT];
    end
    st_nxt.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_CTRL:   st_nxt.rdata = REG_DW'(st_r.hold);
        REG_STATUS: st_nxt.rdata = REG_DW'({st_r.state, st_r.cnt2, st_r.cnt1});
        REG_XPOSE:  st_nxt.rdata = REG_DW'(st_r.xpose);
        default:    st_nxt.rdata = '0;
      endcase
    end
  end

  // Transposition returns to zero through reset or a REF_KEY press in playback
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
      st_r.cnt1 <= CNT_W'(PRELOAD_LEN); // RULE3
      st_r.cnt2 <= CNT_W'(PRELOAD_LEN);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign note_out      = st_r.note;
  assign gate_out      = st_r.gate;
  assign playing_out   = (st_r.state == ST_PLAY);
  assign recording_out = (st_r.state == ST_REC);

  property p_cap_total;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (7'(st_r.cnt1) + 7'(st_r.cnt2)) <= 7'(CAP);
  endproperty
  a_cap_total: assert property (p_cap_total) else $error("banks exceed memory"); // RULE1

  property p_start_first;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(playing_out) |-> st_r.idx == '0 && !gate_out;
  endproperty
  a_start_first: assert property (p_start_first) else $error("play not at first"); // RULE22

  property p_wrap;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (playing_out && tick && !st_r.hold && bank_sel_in == st_r.bank && play_cnt != '0
     && st_r.idx == play_cnt - 1'b1) |=> st_r.idx == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at end"); // RULE12

  property p_step_only_tick;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (playing_out && !tick && bank_sel_in == st_r.bank) |=> $stable(st_r.idx);
  endproperty
  a_step_only_tick: assert property (p_step_only_tick) else $error("step without tick"); // RULE11

  property p_full_clear;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (app_en && first && st_r.cnt1 == CAP) |=> st_r.cnt1 == 6'h01;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full bank not cleared"); // RULE9

  property p_steal;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (app_en && first && st_r.cnt1 != CAP && st_r.cnt1 + st_r.cnt2 >= CAP)
    |=> st_r.cnt2 == '0 && st_r.cnt1 == $past(st_r.cnt1) + 1'b1;
  endproperty
  a_steal: assert property (p_steal) else $error("no steal at limit"); // RULE13 RULE14

  property p_no_lead_rest;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (rest_ev && !note_ev && play_cnt == '0) |-> !app_en;
  endproperty
  a_no_lead_rest: assert property (p_no_lead_rest) else $error("leading rest taken"); // RULE8

  property p_arp_block;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    arp_active_in |=> $stable(st_r.cnt1) && $stable(st_r.cnt2);
  endproperty
  a_arp_block: assert property (p_arp_block) else $error("write under arpeggio"); // RULE18

  property p_xpose;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (playing_out && bank_sel_in == st_r.bank && fresh && key_num_in <= XPOSE_TOP)
    |=> st_r.xpose == $past(key_num_in) - REF_KEY;
  endproperty
  a_xpose: assert property (p_xpose) else $error("transpose wrong"); // RULE16

  property p_rest_gate;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (playing_out && tick && !st_r.hold && bank_sel_in == st_r.bank && play_cnt != '0)
    |=> gate_out == !$past(rd_data[REST_BIT]);
  endproperty
  a_rest_gate: assert property (p_rest_gate) else $error("gate mismatch"); // RULE21

  c_play_wrap: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    playing_out && tick && st_r.idx != '0 ##1 st_r.idx == '0);
  c_steal: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    app_en && play_cnt != CAP && 7'(st_r.cnt1) + 7'(st_r.cnt2) >= 7'(CAP));
  c_rest: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rest_ev && app_en);
endmodule

// ===== verification/sns_panel_model.sv
// Keyboard scanner and external step clock model
`timescale 1ns/1ps
module sns_panel_model
  import sns_pkg::*;
(
  input  wire logic              sys_clk_in,
  output logic                   key_down_out,
  output logic [sns_pkg::KEY_W-1:0] key_num_out,
  output logic                   ext_clk_out
);
  initial begin
    key_down_out = 1'b0;
    key_num_out  = 6'h3f;
    ext_clk_out  = 1'b0;
  end
  // Released key lines show inverted data so a stale code never matches the key just released
  task automatic press(input logic [KEY_W-1:0] k);
    @(posedge sys_clk_in);
    key_down_out <= 1'b1;
    key_num_out  <= k;
    repeat (2) @(posedge sys_clk_in);
    key_down_out <= 1'b0;
    key_num_out  <= ~k;
    repeat (2) @(posedge sys_clk_in);
  endtask
  // Clock rests low between pulses
  task automatic pulse();
    @(posedge sys_clk_in);
    ext_clk_out <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    ext_clk_out <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
  endtask
endmodule

// ===== verification/step_note_sequencer_tb.sv
// Self-checking bench for the step note sequencer
`timescale 1ns/1ps
module step_note_sequencer_tb;
  import sns_pkg::*;
  localparam int SC = 6;
  logic        clk = 1'b0, rst_n = 1'b0, rec = 1'b0, arp = 1'b0, rpt = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, rd_d = 1'b0, was = 1'b0, gap_on = 1'b0;
  logic        kd, ec, gt, pl, rc;
  logic [1:0]  bank = 2'h0, adr = 2'h0;
  logic [15:0] wd = 16'h0000, rdat, f;
  logic [5:0]  kn, k;
  logic [6:0]  nt;
  logic [7:0]  last = 8'h00;
  logic [31:0] e;
  logic [16:0] lf = 17'h1_6d82;
  int          err_total = 0, checks_done = 0, cyc = 0, t0 = -1, i;
  logic [31:0] rq[$];
  logic [15:0] sq[$];

  always #25 clk = ~clk;

  sns_seq_top #(.STEP_PERIOD_NS(SC * 50), .STEP_CYC(SC)) u_dut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .key_down_in(kd), .key_num_in(kn),
    .record_sel_in(rec), .bank_sel_in(bank), .arp_active_in(arp),
    .repeat_external_mode_in(rpt), .ext_clk_in(ec), .reg_addr_in(adr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .note_out(nt),
    .gate_out(gt), .playing_out(pl), .recording_out(rc));

  sns_panel_model u_pm (.sys_clk_in(clk), .key_down_out(kd), .key_num_out(kn),
    .ext_clk_out(ec));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] s);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask

  function automatic logic [15:0] st(input logic [2:0] s, input logic [5:0] c2,
                                     input logic [5:0] c1);
    return {1'b0, s, c2, c1};
  endfunction

  function automatic logic [16:0] nx(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic wrr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= 1'b1;
    @(posedge clk);
    wr  <= 1'b0;
  endtask

  task automatic rdr(input logic [1:0] a, input logic [15:0] x, input logic [15:0] m);
    @(posedge clk);
    adr <= a;
    rd  <= 1'b1;
    rq.push_back({x, m});
    @(posedge clk);
    rd  <= 1'b0;
  endtask

  task automatic go(input logic r, input logic [1:0] b);
    @(posedge clk);
    rec  <= r;
    bank <= b;
    repeat (3) @(posedge clk);
  endtask

  // Panel mode switches: arpeggiator and repeat/external
  task automatic panel(input logic a, input logic p);
    arp <= a;
    rpt <= p;
  endtask

  task automatic rest();
    @(posedge clk);
    rec <= 1'b0;
    repeat (2) @(posedge clk);
    rec <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // Rest steps compare the gate only; their pitch code is left open
  task automatic push(input logic [6:0] n, input logic g);
    sq.push_back({g, g ? n : 7'h00, g ? 8'hff : 8'h80});
  endtask

  task automatic drain();
    int n;
    for (n = 0; n < 500 && sq.size() > 0; n++) @(posedge clk);
    if (sq.size() > 0) begin
      err_total++;
      $display("BAD steps expected 0 seen %0d", sq.size());
      test_done();
    end
  endtask

  // Watches outputs: read data one cycle after a strobe, steps on each output change
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_d) begin
      e = rq.pop_front();
      chk("rdata", e[31:16], rdat & e[15:0]);
    end
    rd_d <= rd;
    if (pl && was && {gt, nt} !== last) begin
      if (gap_on && t0 >= 0) chk("gap", 16'(SC), 16'(cyc - t0));
      t0 <= cyc;
      if (sq.size() == 0) chk("extra_step", 16'h0000, 16'h0001);
      else begin
        f = sq.pop_front();
        chk("step", {8'h00, f[15:8]}, {8'h00, {gt, nt} & f[7:0]});
      end
    end
    if (!pl) t0 <= -1;
    last <= {gt, nt};
    was  <= pl;
  end

  initial begin
    repeat (20000) @(posedge clk);
    $display("BAD watchdog expected 0 seen 1");
    err_total++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdr(REG_STATUS, st(ST_IDLE, 6'h14, 6'h14), 16'hffff);
    rdr(2'h3, 16'h0000, 16'hffff);
    wrr(REG_CTRL, 16'h0001);
    rdr(REG_CTRL, 16'h0001, 16'h0001);
    wrr(REG_CTRL, 16'h0000);
    $display("test registers done");
    gap_on <= 1'b1;
    for (i = 0; i < 20; i++) push(7'(i), 1'b1);
    push(7'h00, 1'b1);
    fork
      repeat (8) u_pm.pulse();
    join_none
    go(1'b0, BANK_FIRST);
    drain();
    go(1'b0, BANK_OFF);
    chk("gate_play", 16'h0000, {14'h0000, gt, pl});
    gap_on <= 1'b0;
    $display("test internal clock done");
    panel(1'b0, 1'b1);
    go(1'b0, BANK_SECOND);
    repeat (30) @(posedge clk);
    for (i = 0; i < 20; i++) push(7'(36 - i), 1'b1);
    push(7'h24, 1'b1);
    repeat (21) u_pm.pulse();
    drain();
    go(1'b0, BANK_OFF);
    panel(1'b0, 1'b0);
    $display("test external clock done");
    // Hold keeps the step index still so the transposed step is known
    wrr(REG_CTRL, 16'h0001);
    go(1'b0, BANK_FIRST);
    u_pm.press(6'h1e);
    rdr(REG_XPOSE, 16'h0000, 16'h003f);
    u_pm.press(6'h07);
    rdr(REG_XPOSE, 16'h003b, 16'h003f);
    for (i = 0; i < 4; i++) push(7'(i - 5), 1'b1);
    wrr(REG_CTRL, 16'h0000);
    drain();
    go(1'b0, BANK_OFF);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdr(REG_STATUS, st(ST_IDLE, 6'h14, 6'h14), 16'hffff);
    rdr(REG_XPOSE, 16'h0000, 16'h003f);
    $display("test transpose done");
    go(1'b1, BANK_SECOND);
    chk("recording", 16'h0001, {15'h0000, rc});
    u_pm.press(6'h05);
    rdr(REG_STATUS, st(ST_REC, 6'h15, 6'h00), 16'hffff);
    rest();
    rdr(REG_STATUS, st(ST_REC, 6'h16, 6'h00), 16'hffff);
    panel(1'b1, 1'b0);
    u_pm.press(6'h08);
    rdr(REG_STATUS, st(ST_REC, 6'h16, 6'h00), 16'hffff);
    panel(1'b0, 1'b0);
    u_pm.press(6'h06);
    rdr(REG_STATUS, st(ST_REC, 6'h17, 6'h00), 16'hffff);
    go(1'b1, BANK_OFF);
    go(1'b0, BANK_OFF);
    gap_on <= 1'b1;
    for (i = 0; i < 20; i++) push(7'(36 - i), 1'b1);
    push(7'h05, 1'b1);
    push(7'h00, 1'b0);
    push(7'h06, 1'b1);
    push(7'h24, 1'b1);
    go(1'b0, BANK_SECOND);
    drain();
    go(1'b0, BANK_OFF);
    gap_on <= 1'b0;
    $display("test record done");
    panel(1'b1, 1'b0);
    go(1'b1, BANK_FIRST);
    chk("recording", 16'h0000, {15'h0000, rc});
    u_pm.press(6'h09);
    rdr(REG_STATUS, st(ST_IDLE, 6'h17, 6'h00), 16'hffff);
    go(1'b1, BANK_OFF);
    panel(1'b0, 1'b0);
    go(1'b1, BANK_FIRST);
    rest();
    rdr(REG_STATUS, st(ST_REC, 6'h17, 6'h00), 16'hffff);
    for (i = 0; i < 41; i++) begin
      lf = nx(lf);
      k = 6'(lf % 37);
      u_pm.press(k);
      if (i == 39) rdr(REG_STATUS, st(ST_REC, 6'h00, 6'h28), 16'hffff);
    end
    rdr(REG_STATUS, st(ST_REC, 6'h00, 6'h01), 16'hffff);
    go(1'b1, BANK_OFF);
    go(1'b0, BANK_OFF);
    push({1'b0, k}, 1'b1);
    go(1'b0, BANK_FIRST);
    drain();
    go(1'b0, BANK_OFF);
    $display("test capacity done");
    test_done();
  end
endmodule
